// ==== rtl/rtc_calendar_alarm_core.sv ====
`timescale 1ns/1ps
`include "rca_defs.svh"
module rtc_calendar_alarm_core #(
   parameter int unsigned PULSE_CYC = `RCA_PULSE_MS * (`RCA_CLK_HZ / `RCA_MS_PER_S),
   parameter logic [6:0] I2C_ADDR = `RCA_I2C_ADDR_DEF
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic osc_input_pin,
   output logic osc_output_pin,
   input wire logic on_backup,
   input wire logic time_load,
   input wire rca_pkg::rca_time_t time_load_val,
   output rca_pkg::rca_time_t time_now,
   input wire logic alarm_enable,
   input wire logic alarm_repeat,
   input wire logic [5:0] alarm_field_en,
   input wire rca_pkg::rca_time_t alarm_val,
   input wire logic alarm_flag_clear,
   output logic alarm_flag,
   input wire logic [3:0] freq_sel,
   output logic alarm_or_clock_out_pin_o,
   output logic alarm_or_clock_out_pin_oe_n,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic [7:0] i2c_tx_data,
   output logic i2c_tx_req,
   output logic [7:0] i2c_rx_data,
   output logic i2c_rx_valid,
   output logic i2c_addr_hit
);

   // -------------------------------------------------
   // state
   // -------------------------------------------------
   typedef struct packed {
      logic osc_q;
      logic osc_out;
      logic [14:0] presc;
      logic tick;
      logic check;
      logic flag;
      logic [24:0] pulse_cnt;
      logic pulse_on;
      logic pin_low;
      logic scl_q;
      logic sda_q;
      rca_pkg::rca_i2c_st_t ist;
      logic [3:0] bits;
      logic [7:0] sh;
      logic rw;
      logic more;
      logic sda_low;
      logic [7:0] rx_data;
      logic rx_valid;
      logic tx_req;
      logic hit;
   } rca_core_state_t;

   rca_core_state_t st_q;
   rca_core_state_t st_d;

   localparam logic [24:0] PULSE_LAST = 25'(PULSE_CYC - 1);

   logic match;
   logic freq_mode;
   logic clk_bit;
   logic [3:0] tap;
   logic osc_rise;
   logic scl_rise;
   logic scl_fall;
   logic i2c_start;
   logic i2c_stop;

   rca_time_if tif ();

   // -------------------------------------------------
   // calendar and alarm comparator
   // -------------------------------------------------
   rca_calendar u_cal (
      .core_clk(core_clk),
      .srst(srst),
      .tif(tif)
   );

   rca_alarm_match u_match (
      .core_clk(core_clk),
      .srst(srst),
      .tif(tif),
      .alarm_val(alarm_val),
      .alarm_field_en(alarm_field_en),
      .armed(alarm_enable && !freq_mode),
      .match(match)
   );

   assign tif.load = time_load;
   assign tif.load_val = time_load_val;
   assign tif.tick = st_q.tick;
   assign tif.check = st_q.check;

   // -------------------------------------------------
   // combinational decode
   // -------------------------------------------------
   // works the same for a crystal or a driven clock on the input pin
   assign osc_rise = osc_input_pin && !st_q.osc_q;
   assign freq_mode = (freq_sel != `RCA_FREQ_OFF);
   assign tap = freq_sel - `RCA_FREQ_BASE;
   assign clk_bit = (freq_sel == `RCA_FREQ_RAW) ? st_q.osc_q : st_q.presc[tap];
   // bus sampling is only valid while on main supply
   assign scl_rise = scl_i && !st_q.scl_q;
   assign scl_fall = !scl_i && st_q.scl_q;
   assign i2c_start = st_q.scl_q && scl_i && st_q.sda_q && !sda_i;
   assign i2c_stop = st_q.scl_q && scl_i && !st_q.sda_q && sda_i;

   // -------------------------------------------------
   // next state
   // -------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.osc_q = osc_input_pin;
      st_d.osc_out = !osc_input_pin; // inverting amplifier output
      st_d.scl_q = scl_i;
      st_d.sda_q = sda_i;
      st_d.tick = 1'b0;
      st_d.check = st_q.tick; // compare once the new second is visible
      st_d.rx_valid = 1'b0;
      st_d.tx_req = 1'b0;

      // timebase prescaler, one tick per 32768 rising edges
      if (osc_rise) begin
         st_d.presc = st_q.presc + 15'h0001;
         st_d.tick = (st_q.presc == `RCA_PRESC_LAST);
      end

      // sticky flag: a match in the clear cycle still sets it
      st_d.flag = (st_q.flag && !alarm_flag_clear) || match;

      // repeat mode pulse; retrigger restarts the full width
      if (match && alarm_repeat) begin
         st_d.pulse_on = 1'b1;
         st_d.pulse_cnt = 25'h0000000;
      end else if (st_q.pulse_on) begin
         if (st_q.pulse_cnt == PULSE_LAST) begin
            st_d.pulse_on = 1'b0;
         end else begin
            st_d.pulse_cnt = st_q.pulse_cnt + 25'h0000001;
         end
      end
      if (freq_mode) begin
         st_d.pulse_on = 1'b0;
      end

      // pin function select
      if (freq_mode) begin
         st_d.pin_low = !clk_bit;
      end else if (alarm_repeat) begin
         st_d.pin_low = st_q.pulse_on;
      end else begin
         st_d.pin_low = st_q.flag;
      end

      // serial target; start and stop override any bit position
      if (on_backup) begin
         st_d.ist = rca_pkg::RCA_IDLE;
         st_d.sda_low = 1'b0;
         st_d.hit = 1'b0;
      end else if (i2c_start) begin
         st_d.ist = rca_pkg::RCA_ADDR;
         st_d.bits = 4'h0;
         st_d.sda_low = 1'b0;
         st_d.hit = 1'b0;
      end else if (i2c_stop) begin
         st_d.ist = rca_pkg::RCA_IDLE;
         st_d.sda_low = 1'b0;
         st_d.hit = 1'b0;
      end else begin
         case (st_q.ist)
            rca_pkg::RCA_ADDR: begin
               if (scl_rise) begin
                  st_d.sh = {st_q.sh[6:0], sda_i};
                  st_d.bits = st_q.bits + 4'h1;
               end else if (scl_fall && st_q.bits == `RCA_BITS_BYTE) begin
                  if (st_q.sh[7:1] == I2C_ADDR) begin
                     st_d.ist = rca_pkg::RCA_ADDR_ACK;
                     st_d.rw = st_q.sh[0];
                     st_d.sda_low = 1'b1;
                     st_d.hit = 1'b1;
                  end else begin
                     st_d.ist = rca_pkg::RCA_IDLE;
                  end
               end
            end
            rca_pkg::RCA_ADDR_ACK, rca_pkg::RCA_READ_ACK: begin
               if (scl_rise && st_q.ist == rca_pkg::RCA_READ_ACK) begin
                  st_d.more = !sda_i;
               end else if (scl_fall) begin
                  st_d.bits = 4'h0;
                  if (st_q.ist == rca_pkg::RCA_READ_ACK && !st_q.more) begin
                     st_d.ist = rca_pkg::RCA_IDLE;
                     st_d.sda_low = 1'b0;
                  end else if (st_q.rw) begin
                     st_d.ist = rca_pkg::RCA_READ;
                     st_d.sh = {i2c_tx_data[6:0], 1'b0};
                     st_d.sda_low = !i2c_tx_data[7];
                     st_d.tx_req = 1'b1;
                  end else begin
                     st_d.ist = rca_pkg::RCA_WRITE;
                     st_d.sda_low = 1'b0;
                  end
               end
            end
            rca_pkg::RCA_WRITE: begin
               if (scl_rise) begin
                  st_d.sh = {st_q.sh[6:0], sda_i};
                  st_d.bits = st_q.bits + 4'h1;
                  if (st_q.bits == `RCA_BITS_BYTE - 4'h1) begin
                     st_d.rx_data = {st_q.sh[6:0], sda_i};
                     st_d.rx_valid = 1'b1;
                  end
               end else if (scl_fall && st_q.bits == `RCA_BITS_BYTE) begin
                  st_d.ist = rca_pkg::RCA_WRITE_ACK;
                  st_d.sda_low = 1'b1;
               end
            end
            rca_pkg::RCA_WRITE_ACK: begin
               if (scl_fall) begin
                  st_d.ist = rca_pkg::RCA_WRITE;
                  st_d.bits = 4'h0;
                  st_d.sda_low = 1'b0;
               end
            end
            rca_pkg::RCA_READ: begin
               if (scl_rise) begin
                  st_d.bits = st_q.bits + 4'h1;
               end else if (scl_fall) begin
                  if (st_q.bits == `RCA_BITS_BYTE) begin
                     st_d.ist = rca_pkg::RCA_READ_ACK;
                     st_d.sda_low = 1'b0; // release for host acknowledge
                     st_d.more = 1'b0;
                  end else begin
                     st_d.sda_low = !st_q.sh[7];
                     st_d.sh = {st_q.sh[6:0], 1'b0};
                  end
               end
            end
            default: begin
               st_d.sda_low = 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------
   // state register
   // -------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_q <= '0;
         st_q.scl_q <= 1'b1;
         st_q.sda_q <= 1'b1;
         st_q.osc_out <= 1'b1;
         st_q.ist <= rca_pkg::RCA_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // -------------------------------------------------
   // outputs; open-drain pins only ever pull low
   // -------------------------------------------------
   assign osc_output_pin = st_q.osc_out;
   assign time_now = tif.now;
   assign alarm_flag = st_q.flag;
   assign alarm_or_clock_out_pin_o = 1'b0;
   assign alarm_or_clock_out_pin_oe_n = !st_q.pin_low;
   assign sda_o = 1'b0;
   assign sda_oe_n = !st_q.sda_low;
   assign i2c_tx_req = st_q.tx_req;
   assign i2c_rx_data = st_q.rx_data;
   assign i2c_rx_valid = st_q.rx_valid;
   assign i2c_addr_hit = st_q.hit;

endmodule

// ==== rtl/rca_defs.svh ====
// Function
// - divide 32.768 kHz timebase to one-second ticks
// - separate seconds, minutes, hours counters
// - separate date, month, year, weekday counters
// - automatic leap year through 2099
// - alarm matches any chosen field combination
// - alarm match sets pollable status flag
// - alarm match can drive interrupt pin
// - repeat mode re-alarms at every match
// - frequency select picks pin function
// - interrupt mode: open-drain, active low
// - frequency mode: raw or divided timebase on pin
// - accept driven 32.768 kHz clock input
// - serial shifts on SCL; ignored on backup
// - SDA driven only by open-drain pull-down
// - repeat mode: pin low 250 ms, flag set
// - frequency output disables the alarm
`ifndef RCA_DEFS_SVH
`define RCA_DEFS_SVH

// -------------------------------------------------
// timebase and timing
// -------------------------------------------------
`define RCA_PRESC_LAST 15'h7FFF
`define RCA_CLK_HZ 100000000
`define RCA_PULSE_MS 250
`define RCA_MS_PER_S 1000

// -------------------------------------------------
// calendar limits and resets
// -------------------------------------------------
`define RCA_SEC_LAST 6'h3B
`define RCA_MIN_LAST 6'h3B
`define RCA_HOUR_LAST 5'h17
`define RCA_MONTH_LAST 4'hC
`define RCA_YEAR_LAST 7'h63
`define RCA_DOW_LAST 3'h6
`define RCA_DATE_FIRST 5'h01
`define RCA_MONTH_FIRST 4'h1
`define RCA_FEB 4'h2
`define RCA_APR 4'h4
`define RCA_JUN 4'h6
`define RCA_SEP 4'h9
`define RCA_NOV 4'hB
`define RCA_DAYS_31 5'h1F
`define RCA_DAYS_30 5'h1E
`define RCA_DAYS_29 5'h1D
`define RCA_DAYS_28 5'h1C

// -------------------------------------------------
// alarm field enables and pin function select
// -------------------------------------------------
`define RCA_AEN_SEC 0
`define RCA_AEN_MIN 1
`define RCA_AEN_HOUR 2
`define RCA_AEN_DATE 3
`define RCA_AEN_MONTH 4
`define RCA_AEN_DOW 5
`define RCA_FREQ_OFF 4'h0
`define RCA_FREQ_RAW 4'h1
`define RCA_FREQ_BASE 4'h2

// -------------------------------------------------
// serial port
// -------------------------------------------------
`define RCA_BITS_BYTE 4'h8
`define RCA_I2C_ADDR_DEF 7'h55

`endif

// ==== rtl/rca_pkg.sv ====
package rca_pkg;

   // binary time and calendar value, year counts from 2000
   typedef struct packed {
      logic [5:0] sec;
      logic [5:0] min;
      logic [4:0] hour;
      logic [4:0] date;
      logic [3:0] month;
      logic [6:0] year;
      logic [2:0] dow;
   } rca_time_t;

   typedef enum logic [2:0] {
      RCA_IDLE = 3'h0,
      RCA_ADDR = 3'h1,
      RCA_ADDR_ACK = 3'h2,
      RCA_WRITE = 3'h3,
      RCA_WRITE_ACK = 3'h4,
      RCA_READ = 3'h5,
      RCA_READ_ACK = 3'h6
   } rca_i2c_st_t;

endpackage

// ==== rtl/rca_time_if.sv ====
`timescale 1ns/1ps
interface rca_time_if;
   rca_pkg::rca_time_t now;
   rca_pkg::rca_time_t load_val;
   logic load;
   logic tick;
   logic check;

   modport cal (input load, input load_val, input tick, output now);
   modport mon (input now, input check);
   modport core (output load, output load_val, output tick, output check, input now);
endinterface

// ==== rtl/rca_calendar.sv ====
`timescale 1ns/1ps
`include "rca_defs.svh"
module rca_calendar (
   input wire logic core_clk,
   input wire logic srst,
   rca_time_if.cal tif
);

   typedef struct packed {
      rca_pkg::rca_time_t t;
   } rca_cal_state_t;

   rca_cal_state_t st_q;
   rca_cal_state_t st_d;

   // leap rule of every fourth year holds for 2000 through 2099
   function automatic logic [4:0] rca_days(input logic [3:0] m, input logic [6:0] y);
      if (m == `RCA_FEB) begin
         rca_days = (y[1:0] == 2'h0) ? `RCA_DAYS_29 : `RCA_DAYS_28;
      end else if (m == `RCA_APR || m == `RCA_JUN || m == `RCA_SEP || m == `RCA_NOV) begin
         rca_days = `RCA_DAYS_30;
      end else begin
         rca_days = `RCA_DAYS_31;
      end
   endfunction

   // ripple carry through the time fields, load wins over a tick
   always_comb begin
      st_d = st_q;
      if (tif.load) begin
         st_d.t = tif.load_val;
      end else if (tif.tick) begin
         if (st_q.t.sec != `RCA_SEC_LAST) begin
            st_d.t.sec = st_q.t.sec + 6'h01;
         end else begin
            st_d.t.sec = 6'h00;
            if (st_q.t.min != `RCA_MIN_LAST) begin
               st_d.t.min = st_q.t.min + 6'h01;
            end else begin
               st_d.t.min = 6'h00;
               if (st_q.t.hour != `RCA_HOUR_LAST) begin
                  st_d.t.hour = st_q.t.hour + 5'h01;
               end else begin
                  st_d.t.hour = 5'h00;
                  // midnight: weekday cycles, date rolls the month
                  st_d.t.dow = (st_q.t.dow == `RCA_DOW_LAST) ? 3'h0 : st_q.t.dow + 3'h1;
                  if (st_q.t.date < rca_days(st_q.t.month, st_q.t.year)) begin
                     st_d.t.date = st_q.t.date + 5'h01;
                  end else begin
                     st_d.t.date = `RCA_DATE_FIRST;
                     if (st_q.t.month < `RCA_MONTH_LAST) begin
                        st_d.t.month = st_q.t.month + 4'h1;
                     end else begin
                        st_d.t.month = `RCA_MONTH_FIRST;
                        st_d.t.year = (st_q.t.year == `RCA_YEAR_LAST) ? 7'h00 :
                                      st_q.t.year + 7'h01;
                     end
                  end
               end
            end
         end
      end
   end

   // state register, reset to 2000-01-01 00:00:00
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_q <= '0;
         st_q.t.date <= `RCA_DATE_FIRST;
         st_q.t.month <= `RCA_MONTH_FIRST;
      end else begin
         st_q <= st_d;
      end
   end

   assign tif.now = st_q.t;

endmodule

// ==== rtl/rca_alarm_match.sv ====
`timescale 1ns/1ps
`include "rca_defs.svh"
module rca_alarm_match (
   input wire logic core_clk,
   input wire logic srst,
   rca_time_if.mon tif,
   input wire rca_pkg::rca_time_t alarm_val,
   input wire logic [5:0] alarm_field_en,
   input wire logic armed,
   output logic match
);

   typedef struct packed {
      logic hit;
   } rca_match_state_t;

   rca_match_state_t st_q;
   rca_match_state_t st_d;
   logic fields_ok;

   // every enabled field must agree; no enabled field means no alarm
   always_comb begin
      fields_ok = 1'b1;
      if (alarm_field_en[`RCA_AEN_SEC] && tif.now.sec != alarm_val.sec) fields_ok = 1'b0;
      if (alarm_field_en[`RCA_AEN_MIN] && tif.now.min != alarm_val.min) fields_ok = 1'b0;
      if (alarm_field_en[`RCA_AEN_HOUR] && tif.now.hour != alarm_val.hour) fields_ok = 1'b0;
      if (alarm_field_en[`RCA_AEN_DATE] && tif.now.date != alarm_val.date) fields_ok = 1'b0;
      if (alarm_field_en[`RCA_AEN_MONTH] && tif.now.month != alarm_val.month) fields_ok = 1'b0;
      if (alarm_field_en[`RCA_AEN_DOW] && tif.now.dow != alarm_val.dow) fields_ok = 1'b0;
      st_d.hit = tif.check && armed && (|alarm_field_en) && fields_ok;
   end

   // one pulse per second at most, so repeats come once per match
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign match = st_q.hit;

endmodule

// ==== bench/rca_core_asserts.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port checks on the clock core
// ----------------------------------------
module rca_core_asserts #(
   parameter int unsigned PULSE_CYC = 20
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic osc_input_pin,
   input wire logic osc_output_pin,
   input wire logic on_backup,
   input wire logic alarm_repeat,
   input wire logic alarm_flag_clear,
   input wire logic alarm_flag,
   input wire logic [3:0] freq_sel,
   input wire logic alarm_or_clock_out_pin_o,
   input wire logic alarm_or_clock_out_pin_oe_n,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   input wire logic i2c_tx_req,
   input wire logic i2c_rx_valid,
   input wire logic i2c_addr_hit
);
   logic [31:0] low_cnt_q;
   logic [31:0] low_cnt_d;

   // length of the current low stretch on the shared pin
   always_comb begin
      low_cnt_d = alarm_or_clock_out_pin_oe_n ? 32'h0 : low_cnt_q + 32'h1;
   end
   always_ff @(posedge core_clk) begin
      low_cnt_q <= srst ? 32'h0 : low_cnt_d;
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   // open-drain pins never drive high
   sda_open_a: assert property (sda_o == 1'b0)
      else $error("sda data bit not low");
   pin_open_a: assert property (alarm_or_clock_out_pin_o == 1'b0)
      else $error("shared pin data bit not low");
   // backup supply silences the serial port after its sync delay
   backup_quiet_a: assert property (on_backup [*3] |-> sda_oe_n)
      else $error("sda pulled low on backup");
   backup_nohit_a: assert property (on_backup [*3] |-> !i2c_addr_hit && !i2c_rx_valid)
      else $error("serial traffic on backup");
   rx_hit_a: assert property (i2c_rx_valid || i2c_tx_req |-> i2c_addr_hit)
      else $error("byte moved without address hit");
   freq_quiet_a: assert property ((freq_sel != 4'h0) [*3] |-> !$rose(alarm_flag))
      else $error("alarm raised in clock output mode");
   flag_pin_a: assert property ($rose(alarm_flag) && freq_sel == 4'h0 |=>
      !alarm_or_clock_out_pin_oe_n)
      else $error("pin not low after alarm");
   pulse_len_a: assert property (alarm_flag && alarm_repeat && freq_sel == 4'h0 &&
      $rose(alarm_or_clock_out_pin_oe_n) |-> low_cnt_q == PULSE_CYC)
      else $error("repeat pulse length wrong");
   flag_hold_a: assert property (alarm_flag && !alarm_flag_clear |=> alarm_flag)
      else $error("alarm flag dropped");
   flag_clear_a: assert property ($fell(alarm_flag) |-> $past(alarm_flag_clear))
      else $error("alarm flag fell without clear");
   osc_inv_a: assert property (!$past(srst) |->
      osc_output_pin == !$past(osc_input_pin))
      else $error("oscillator output not inverse");

   cover property ($rose(alarm_flag));
   cover property ($rose(i2c_addr_hit));
   cover property (i2c_rx_valid);
   cover property (i2c_tx_req);
endmodule

bind rtc_calendar_alarm_core rca_core_asserts #(.PULSE_CYC(PULSE_CYC)) chk_u (
   .core_clk(core_clk), .srst(srst), .osc_input_pin(osc_input_pin),
   .osc_output_pin(osc_output_pin), .on_backup(on_backup), .alarm_repeat(alarm_repeat),
   .alarm_flag_clear(alarm_flag_clear), .alarm_flag(alarm_flag), .freq_sel(freq_sel),
   .alarm_or_clock_out_pin_o(alarm_or_clock_out_pin_o),
   .alarm_or_clock_out_pin_oe_n(alarm_or_clock_out_pin_oe_n), .sda_o(sda_o),
   .sda_oe_n(sda_oe_n), .i2c_tx_req(i2c_tx_req), .i2c_rx_valid(i2c_rx_valid),
   .i2c_addr_hit(i2c_addr_hit));

// ==== bench/rca_i2c_host.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// host bus master, slow quarter-bit timing
// ----------------------------------------
module rca_i2c_host (
   input wire logic core_clk,
   input wire logic sda_oe_n,
   output logic scl,
   output wire logic sda
);
   logic host_sda = 1'b1;

   // pull-up wins only when nobody pulls low
   assign sda = host_sda & sda_oe_n;

   initial begin
      scl = 1'b1;
   end

   task automatic wait_c(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic start;
      host_sda = 1'b0;
      wait_c(10);
      scl = 1'b0;
      wait_c(5);
   endtask

   task automatic stop;
      host_sda = 1'b0;
      wait_c(5);
      scl = 1'b1;
      wait_c(10);
      host_sda = 1'b1;
      wait_c(10);
   endtask

   // data moves a quarter bit after scl falls, so no false start or stop
   task automatic bit_x(input logic b, output logic r);
      host_sda = b;
      wait_c(5);
      scl = 1'b1;
      wait_c(10);
      r = sda;
      scl = 1'b0;
      wait_c(5);
   endtask

   task automatic wr(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], r);
      end
      bit_x(1'b1, r);
      ack = ~r;
   endtask

   task automatic rd(input logic nack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, b[i]);
      end
      bit_x(nack, r);
   endtask
endmodule

// ==== bench/rtc_calendar_alarm_core_test.sv ====
`timescale 1ns/1ps
module rtc_calendar_alarm_core_test;
   // ----------------------------------------
   // stimulus and wiring
   // ----------------------------------------
   localparam int unsigned PULSE = 20;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic osc = 1'b0;
   logic on_backup = 1'b0;
   logic time_load = 1'b0;
   rca_pkg::rca_time_t load_val = 36'h0;
   rca_pkg::rca_time_t alarm_val = 36'h0;
   rca_pkg::rca_time_t time_now;
   logic alarm_enable = 1'b0;
   logic alarm_repeat = 1'b0;
   logic [5:0] field_en = 6'h00;
   logic flag_clr = 1'b0;
   logic alarm_flag;
   logic [3:0] freq_sel = 4'h0;
   logic pin_oe_n;
   wire logic scl;
   wire logic sda;
   logic sda_oe_n;
   logic [7:0] tx_data = 8'h00;
   logic [7:0] rx_data;
   logic rx_valid;
   logic [7:0] last_rx = 8'h00;
   logic [7:0] rx_cnt = 8'h00;
   int errors = 0;
   int checked = 0;
   int cyc = 0;

   rtc_calendar_alarm_core #(.PULSE_CYC(PULSE)) dut_u (
      .core_clk(core_clk), .srst(srst), .osc_input_pin(osc), .osc_output_pin(),
      .on_backup(on_backup), .time_load(time_load), .time_load_val(load_val),
      .time_now(time_now), .alarm_enable(alarm_enable), .alarm_repeat(alarm_repeat),
      .alarm_field_en(field_en), .alarm_val(alarm_val), .alarm_flag_clear(flag_clr),
      .alarm_flag(alarm_flag), .freq_sel(freq_sel), .alarm_or_clock_out_pin_o(),
      .alarm_or_clock_out_pin_oe_n(pin_oe_n), .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe_n(sda_oe_n), .i2c_tx_data(tx_data), .i2c_tx_req(), .i2c_rx_data(rx_data),
      .i2c_rx_valid(rx_valid), .i2c_addr_hit());

   rca_i2c_host host_u (.core_clk(core_clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

   // clock, and a 3-cycle timebase: slowest legal rate would blow the run length
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      forever begin
         @(posedge core_clk);
         #1 osc = 1'b1;
         @(posedge core_clk);
         #1 osc = 1'b0;
         @(posedge core_clk);
      end
   end

   // received bytes and hang guard
   always @(posedge core_clk) begin
      if (rx_valid === 1'b1) begin
         last_rx <= rx_data;
         rx_cnt <= rx_cnt + 8'h01;
      end
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         errors++;
         end_sim();
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset;
      chk("time", {6'h00, 6'h00, 5'h00, 5'h01, 4'h1, 7'h00, 3'h0}, time_now);
      chk("flag", 36'h0, alarm_flag);
      chk("pin", 36'h1, pin_oe_n);
      chk("sda", 36'h1, sda_oe_n);
      load_val = {6'h3B, 6'h3B, 5'h17, 5'h1C, 4'h2, 7'h04, 3'h6};
      time_load = 1'b1;
      step(1);
      time_load = 1'b0;
      chk("load", load_val, time_now);
   endtask

   // edge count of the pin for raw, 1st and 2nd divider taps
   task automatic test_freq;
      int n;
      logic prev;
      for (int s = 1; s <= 3; s++) begin
         freq_sel = s[3:0];
         step(6);
         n = 0;
         prev = pin_oe_n;
         for (int i = 0; i < 96; i++) begin
            step(1);
            if (pin_oe_n !== prev) n++;
            prev = pin_oe_n;
         end
         chk("edges", 36'h1, n >= (128 >> s) - 1 && n <= (128 >> s) + 1);
      end
      freq_sel = 4'h0;
      step(4);
      chk("pin", 36'h1, pin_oe_n);
   endtask

   task automatic test_i2c;
      logic ack;
      logic [7:0] b;
      host_u.start();
      host_u.wr(8'hAA, ack);
      chk("ack", 36'h1, ack);
      host_u.wr(8'hA5, ack);
      host_u.stop();
      chk("ack", 36'h1, ack);
      chk("rx", 36'hA5, last_rx);
      tx_data = 8'hC3;
      host_u.start();
      host_u.wr(8'hAB, ack);
      host_u.rd(1'b1, b);
      host_u.stop();
      chk("read", 36'hC3, b);
      // another target address must be left alone
      host_u.start();
      host_u.wr(8'h54, ack);
      host_u.stop();
      chk("ack", 36'h0, ack);
      on_backup = 1'b1;
      step(4);
      host_u.start();
      host_u.wr(8'hAA, ack);
      host_u.stop();
      on_backup = 1'b0;
      chk("ack", 36'h0, ack);
      chk("count", 36'h1, rx_cnt);
   endtask

   // one tick across a leap-year midnight with a repeat alarm on 00:00
   task automatic test_alarm;
      int n;
      alarm_val = {6'h00, 6'h00, 5'h00, 5'h1D, 4'h2, 7'h00, 3'h0};
      field_en = 6'h3F;
      alarm_repeat = 1'b1;
      alarm_enable = 1'b1;
      n = 0;
      while (time_now === load_val && n < 100000) begin
         step(1);
         n++;
      end
      chk("tick", {6'h00, 6'h00, 5'h00, 5'h1D, 4'h2, 7'h04, 3'h0}, time_now);
      n = 0;
      while (alarm_flag !== 1'b1 && n < 5) begin
         step(1);
         n++;
      end
      chk("flag", 36'h1, alarm_flag);
      step(1);
      chk("pin", 36'h0, pin_oe_n);
      n = 0;
      while (pin_oe_n === 1'b0 && n < 100) begin
         step(1);
         n++;
      end
      chk("pulse", PULSE, n);
      chk("flag", 36'h1, alarm_flag);
      // single event mode: pin follows the still-set flag
      step(1);
      alarm_repeat = 1'b0;
      step(2);
      chk("pin", 36'h0, pin_oe_n);
      flag_clr = 1'b1;
      step(1);
      flag_clr = 1'b0;
      step(1);
      chk("flag", 36'h0, alarm_flag);
      chk("pin", 36'h1, pin_oe_n);
   endtask

   initial begin
      step(16);
      srst = 1'b0;
      step(1);
      test_reset();
      test_freq();
      test_i2c();
      test_alarm();
      end_sim();
   end
endmodule
